// file: logic/tcm_timer_compare_control.sv
// compare values, control and status of a 16-bit / dual 8-bit timer
// assumes external counter halves that increment on tick and zero on clear
`timescale 1ns/1ns

module tcm_timer_compare_control (
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    input  wire logic [1:0] addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    output logic      [7:0] rd_data_o,
    input  wire logic [7:0] counter_high_i,
    input  wire logic [7:0] counter_low_i,
    input  wire logic       event_input_pin_i,
    input  wire logic       event_edge_select_i,
    output logic            tick_high_o,
    output logic            tick_low_o,
    output logic            clear_high_o,
    output logic            clear_low_o,
    output logic            toggle_pin_high_o,
    output logic            toggle_pin_low_o,
    output logic            irq_request_high_o,
    output logic            irq_request_low_o
);

    // ==========================================================
    // registers
    logic [7:0]                         compare_value_high;
    logic [7:0]                         compare_value_low;
    logic [7:0]                         hold_byte;
    tcm_pkg::tcm_ctrl_s                 timer_control;
    logic [7:0]                         timer_status_control;
    logic [tcm_pkg::TCM_NUM_FLAGS-1:0]  flag_armed;
    logic [tcm_pkg::TCM_PRE_W-1:0]      prescale;
    logic                               event_prev;

    // ==========================================================
    // decode
    logic ctrl_wr;
    logic status_wr;
    logic status_rd;
    logic mode_8bit;

    assign ctrl_wr   = wr_en_i && addr_i == tcm_pkg::TCM_ADDR_CONTROL;
    assign status_wr = wr_en_i && addr_i == tcm_pkg::TCM_ADDR_STATUS;
    assign status_rd = rd_en_i && addr_i == tcm_pkg::TCM_ADDR_STATUS;
    assign mode_8bit = timer_control.clock_select_high[2];

    // ==========================================================
    // rate enables and event edge
    function automatic logic div_tick(input logic [1:0] sel,
                                      input logic [4:0] pre);
        case (sel)
            tcm_pkg::TCM_DIV_32: div_tick = &pre[4:0];
            tcm_pkg::TCM_DIV_16: div_tick = &pre[3:0];
            tcm_pkg::TCM_DIV_4:  div_tick = &pre[1:0];
            tcm_pkg::TCM_DIV_2:  div_tick = pre[0];
            default:             div_tick = 1'b0;
        endcase
    endfunction

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            prescale <= '0;
        else
            prescale <= prescale + 1'b1;
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            event_prev <= 1'b0;
        else
            event_prev <= event_input_pin_i;
    end

    logic event_edge;
    assign event_edge = event_edge_select_i
                      ? (event_input_pin_i && !event_prev)
                      : (!event_input_pin_i && event_prev);

    // ==========================================================
    // tick, rollover and match detection
    logic next_tick_low;
    logic next_tick_high;
    logic low_ovf;
    logic high_ovf;
    logic low_hit;
    logic high_hit;
    logic next_clear_high;
    logic next_clear_low;

    always_comb
    begin
        next_tick_low  = timer_control.clock_select_low[2]
                       ? div_tick(timer_control.clock_select_low[1:0],
                                  prescale)
                       : event_edge;
        low_ovf        = next_tick_low
                       && counter_low_i == tcm_pkg::TCM_COUNT_TOP;
        next_tick_high = mode_8bit
                       ? div_tick(timer_control.clock_select_high[1:0],
                                  prescale)
                       : low_ovf;
        high_ovf       = next_tick_high
                       && counter_high_i == tcm_pkg::TCM_COUNT_TOP;
        low_hit        = next_tick_low
                       && counter_low_i == compare_value_low;
        if (mode_8bit)
            high_hit   = next_tick_high
                       && counter_high_i == compare_value_high;
        else
            high_hit   = next_tick_low
                       && {counter_high_i, counter_low_i}
                          == {compare_value_high, compare_value_low};
        next_clear_high = high_hit
                        && timer_status_control[tcm_pkg::TCM_ST_CCLR_HI];
        if (mode_8bit)
            next_clear_low = low_hit
                && timer_status_control[tcm_pkg::TCM_ST_CCLR_LO];
        else
            next_clear_low = next_clear_high;
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tick_high_o  <= 1'b0;
            tick_low_o   <= 1'b0;
            clear_high_o <= 1'b0;
            clear_low_o  <= 1'b0;
        end
        else
        begin
            tick_high_o  <= next_tick_high;
            tick_low_o   <= next_tick_low;
            clear_high_o <= next_clear_high;
            clear_low_o  <= next_clear_low;
        end
    end

    // ==========================================================
    // interrupt request pulses
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_request_high_o <= 1'b0;
            irq_request_low_o  <= 1'b0;
        end
        else
        begin
            irq_request_high_o <= high_hit || (high_ovf
                && timer_status_control[tcm_pkg::TCM_ST_OVIE_HI]);
            irq_request_low_o  <= (mode_8bit && low_hit)
                || (low_ovf
                && timer_status_control[tcm_pkg::TCM_ST_OVIE_LO]);
        end
    end

    // ==========================================================
    // toggle outputs, a control write wins over a match
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            toggle_pin_high_o <= 1'b0;
            toggle_pin_low_o  <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            toggle_pin_high_o <= wr_data_i[7];
            toggle_pin_low_o  <= wr_data_i[3];
        end
        else
        begin
            if (high_hit)
                toggle_pin_high_o <= !toggle_pin_high_o;
            if (low_hit)
                toggle_pin_low_o  <= !toggle_pin_low_o;
        end
    end

    // ==========================================================
    // control register
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            timer_control <= tcm_pkg::TCM_CTRL_RESET;
        else if (ctrl_wr)
            timer_control <= wr_data_i;
    end

    // ==========================================================
    // compare values and holding byte
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            compare_value_high <= tcm_pkg::TCM_CMP_RESET;
            compare_value_low  <= tcm_pkg::TCM_CMP_RESET;
            hold_byte          <= tcm_pkg::TCM_CMP_RESET;
        end
        else if (wr_en_i && addr_i == tcm_pkg::TCM_ADDR_CMP_HI)
        begin
            if (mode_8bit)
                compare_value_high <= wr_data_i;
            else
                hold_byte <= wr_data_i;
        end
        else if (wr_en_i && addr_i == tcm_pkg::TCM_ADDR_CMP_LO)
        begin
            compare_value_low <= wr_data_i;
            if (!mode_8bit)
                compare_value_high <= hold_byte;
        end
    end

    // ==========================================================
    // status register
    logic [tcm_pkg::TCM_NUM_FLAGS-1:0] flag_set;
    logic [tcm_pkg::TCM_NUM_FLAGS-1:0] flag_bit;
    logic [7:0]                        enable_bits;
    assign flag_set = {high_ovf, high_hit, low_ovf, low_hit};

    always_comb
    begin
        timer_status_control = enable_bits;
        for (int i = 0; i < tcm_pkg::TCM_NUM_FLAGS; i++)
            timer_status_control[tcm_pkg::TCM_FLAG_POS[i]] = flag_bit[i];
    end

    genvar gi;
    generate
        for (gi = 0; gi < tcm_pkg::TCM_NUM_FLAGS; gi++)
        begin : g_flag
            localparam int P = tcm_pkg::TCM_FLAG_POS[gi];
            always_ff @(posedge mclk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    flag_bit[gi]            <= 1'b0;
                    flag_armed[gi]          <= 1'b0;
                end
                else if (flag_set[tcm_pkg::TCM_NUM_FLAGS-1-gi])
                begin
                    flag_bit[gi]            <= 1'b1;
                end
                else if (status_wr && !wr_data_i[P] && flag_armed[gi])
                begin
                    flag_bit[gi]            <= 1'b0;
                    flag_armed[gi]          <= 1'b0;
                end
                else if (status_rd && flag_bit[gi])
                begin
                    flag_armed[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            enable_bits <= tcm_pkg::TCM_STATUS_RESET;
        else if (status_wr)
            enable_bits <= {2'b00, wr_data_i[5:4], 2'b00, wr_data_i[1:0]};
    end

    // ==========================================================
    // read port
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rd_data_o <= tcm_pkg::TCM_READ_ZERO;
        else if (rd_en_i)
        begin
            case (addr_i)
                tcm_pkg::TCM_ADDR_STATUS: rd_data_o <= timer_status_control;
                tcm_pkg::TCM_ADDR_CMP_HI: rd_data_o <= compare_value_high;
                tcm_pkg::TCM_ADDR_CMP_LO: rd_data_o <= compare_value_low;
                default:                  rd_data_o <= tcm_pkg::TCM_READ_ZERO;
            endcase
        end
        else
            rd_data_o <= tcm_pkg::TCM_READ_ZERO;
    end

    // ==========================================================
    // checks
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_no_ctrl_write2;
        !ctrl_wr ##1 !ctrl_wr;
    endsequence

    sequence s_half_rate;
        !tick_high_o ##1 tick_high_o;
    endsequence

    a_pair_write_hold: assert property (
        (wr_en_i && addr_i == tcm_pkg::TCM_ADDR_CMP_LO && !mode_8bit)
        |=> compare_value_high == $past(hold_byte))
        else $error("paired write did not use holding byte");

    a_match_high_flag: assert property (
        high_hit |=> timer_status_control[tcm_pkg::TCM_ST_CMF_HI]
                     && irq_request_high_o)
        else $error("high match did not set flag and request");

    a_match_toggles: assert property (
        (high_hit && !ctrl_wr)
        |=> toggle_pin_high_o != $past(toggle_pin_high_o))
        else $error("high pin did not toggle on match");

    a_low_match_req: assert property (
        (mode_8bit && low_hit)
        |=> irq_request_low_o && timer_status_control[tcm_pkg::TCM_ST_CMF_LO])
        else $error("low match did not request");

    a_control_unread: assert property (
        (rd_en_i && addr_i == tcm_pkg::TCM_ADDR_CONTROL)
        |=> rd_data_o == tcm_pkg::TCM_READ_ZERO)
        else $error("control register read back nonzero");

    a_level_write: assert property (
        ctrl_wr |=> toggle_pin_high_o == $past(wr_data_i[7])
                    && toggle_pin_low_o == $past(wr_data_i[3]))
        else $error("pin level not taken from control write");

    a_div2_rate: assert property (
        (s_no_ctrl_write2
         ##0 (tick_high_o && timer_control.clock_select_high == 3'h7))
        |=> s_half_rate)
        else $error("high half-rate tick spacing wrong");

    a_event_tick: assert property (
        (!timer_control.clock_select_low[2] && event_edge) |=> tick_low_o)
        else $error("event edge not counted");

    a_flag_cause: assert property (
        $rose(timer_status_control[tcm_pkg::TCM_ST_OVF_HI])
        |-> $past(high_ovf))
        else $error("rollover flag rose without rollover");

    a_clear_on_match: assert property (
        (high_hit && timer_status_control[tcm_pkg::TCM_ST_CCLR_HI])
        |=> clear_high_o && (mode_8bit || clear_low_o))
        else $error("counter clear on match missing");

    a_set_beats_clear: assert property (
        (low_ovf && status_wr)
        |=> timer_status_control[tcm_pkg::TCM_ST_OVF_LO])
        else $error("software clear beat hardware set");

endmodule // tcm_timer_compare_control

// file: logic/tcm_pkg.sv
// constants, register map and carrier types for the timer compare control
// assumes an 8-bit register port and external 8-bit counter halves
package tcm_pkg;

    // ==========================================================
    // register map (word index on the register port)
    localparam logic [1:0] TCM_ADDR_CONTROL = 2'h0;
    localparam logic [1:0] TCM_ADDR_STATUS  = 2'h1;
    localparam logic [1:0] TCM_ADDR_CMP_HI  = 2'h2;
    localparam logic [1:0] TCM_ADDR_CMP_LO  = 2'h3;

    // ==========================================================
    // reset values and the counter top value
    localparam logic [7:0] TCM_CMP_RESET    = 8'hFF;
    localparam logic [7:0] TCM_CTRL_RESET   = 8'h00;
    localparam logic [7:0] TCM_STATUS_RESET = 8'h00;
    localparam logic [7:0] TCM_COUNT_TOP    = 8'hFF;
    localparam logic [7:0] TCM_READ_ZERO    = 8'h00;

    // ==========================================================
    // status field positions
    localparam int TCM_ST_OVF_HI  = 7;
    localparam int TCM_ST_CMF_HI  = 6;
    localparam int TCM_ST_OVIE_HI = 5;
    localparam int TCM_ST_CCLR_HI = 4;
    localparam int TCM_ST_OVF_LO  = 3;
    localparam int TCM_ST_CMF_LO  = 2;
    localparam int TCM_ST_OVIE_LO = 1;
    localparam int TCM_ST_CCLR_LO = 0;
    localparam int TCM_NUM_FLAGS  = 4;
    localparam int TCM_FLAG_POS [TCM_NUM_FLAGS] = '{7, 6, 3, 2};

    // ==========================================================
    // clock select codes (low two bits once the msb is set)
    localparam logic [1:0] TCM_DIV_32 = 2'h0;
    localparam logic [1:0] TCM_DIV_16 = 2'h1;
    localparam logic [1:0] TCM_DIV_4  = 2'h2;
    localparam logic [1:0] TCM_DIV_2  = 2'h3;
    localparam int         TCM_PRE_W  = 5;

    // ==========================================================
    // control register layout, msb first
    typedef struct packed {
        logic       output_level_high;
        logic [2:0] clock_select_high;
        logic       output_level_low;
        logic [2:0] clock_select_low;
    } tcm_ctrl_s;

endpackage

// file: testbench/test_timer_compare_control.sv
// self-checking bench for the timer compare control block
// assumes bench-owned counter halves that follow the tick and clear pulses
`timescale 1ns/1ns
module test_timer_compare_control;
    logic       mclk_i              = 1'b0;
    logic       resetn_i            = 1'b0;
    logic [1:0] addr_i              = 2'h0;
    logic [7:0] wr_data_i           = 8'h00;
    logic       wr_en_i             = 1'b0;
    logic       rd_en_i             = 1'b0;
    logic [7:0] counter_high_i      = 8'h00;
    logic [7:0] counter_low_i       = 8'h00;
    logic       event_input_pin_i   = 1'b0;
    logic       event_edge_select_i = 1'b1;
    logic [7:0] rd_data_o;
    logic       tick_high_o;
    logic       tick_low_o;
    logic       clear_high_o;
    logic       clear_low_o;
    logic       toggle_pin_high_o;
    logic       toggle_pin_low_o;
    logic       irq_request_high_o;
    logic       irq_request_low_o;
    logic [7:0] exp_q [$];
    logic [7:0] per64 [4] = '{8'h02, 8'h04, 8'h10, 8'h20};
    logic       rd_pend     = 1'b0;
    logic       zero_req    = 1'b0;
    logic [15:0] preload    = 16'h0000;
    int         fail_count  = 0;
    int         comparisons = 0;
    int         th_cnt      = 0;
    int         tl_cnt      = 0;
    int         cyc         = 0;
    int         seed        = 32'h5ED2831A;
    int         w;
    int         ok;

    tcm_timer_compare_control tcm_timer_compare_control_inst (
        .mclk_i              (mclk_i),
        .resetn_i            (resetn_i),
        .addr_i              (addr_i),
        .wr_data_i           (wr_data_i),
        .wr_en_i             (wr_en_i),
        .rd_en_i             (rd_en_i),
        .rd_data_o           (rd_data_o),
        .counter_high_i      (counter_high_i),
        .counter_low_i       (counter_low_i),
        .event_input_pin_i   (event_input_pin_i),
        .event_edge_select_i (event_edge_select_i),
        .tick_high_o         (tick_high_o),
        .tick_low_o          (tick_low_o),
        .clear_high_o        (clear_high_o),
        .clear_low_o         (clear_low_o),
        .toggle_pin_high_o   (toggle_pin_high_o),
        .toggle_pin_low_o    (toggle_pin_low_o),
        .irq_request_high_o  (irq_request_high_o),
        .irq_request_low_o   (irq_request_low_o)
    );

    always #4 mclk_i = ~mclk_i;

    // ==========================================================
    // counter halves outside the block
    always @(posedge mclk_i)
    begin
        if (zero_req)
            counter_high_i <= preload[15:8];
        else if (clear_high_o)
            counter_high_i <= 8'h00;
        else if (tick_high_o)
            counter_high_i <= counter_high_i + 8'h01;
        if (zero_req)
            counter_low_i <= preload[7:0];
        else if (clear_low_o)
            counter_low_i <= 8'h00;
        else if (tick_low_o)
            counter_low_i <= counter_low_i + 8'h01;
    end

    // ==========================================================
    // read data scoreboard, tick counting, timeout
    always @(posedge mclk_i)
    begin
        if (rd_pend)
            check(rd_data_o, exp_q.pop_front());
        rd_pend <= rd_en_i;
        if (tick_high_o === 1'b1)
            th_cnt++;
        if (tick_low_o === 1'b1)
            tl_cnt++;
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            results();
        end
    end

    // ==========================================================
    // tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        check({7'h00, got}, {7'h00, exp});
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_en_i   <= 1'b1;
        addr_i    <= a;
        wr_data_i <= d;
        @(posedge mclk_i);
        wr_en_i   <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        rd_en_i <= 1'b1;
        addr_i  <= a;
        exp_q.push_back(e);
        @(posedge mclk_i);
        rd_en_i <= 1'b0;
    endtask

    task automatic zero_counters();
        @(posedge mclk_i);
        zero_req <= 1'b1;
        @(posedge mclk_i);
        zero_req <= 1'b0;
    endtask

    function automatic logic hit(input int sel);
        case (sel)
            0: return clear_low_o === 1'b1;
            1: return clear_high_o === 1'b1;
            3: return irq_request_high_o === 1'b1
                      && {counter_high_i, counter_low_i} === 16'hFFFF;
            default: return irq_request_low_o === 1'b1
                            && counter_low_i === 8'hFF;
        endcase
    endfunction

    task automatic wait_on(input int sel, input int n);
        ok = 0;
        for (int i = 0; i < n && ok == 0; i++)
        begin
            @(posedge mclk_i);
            #1;
            ok = int'(hit(sel));
        end
        chk1(ok[0], 1'b1);
    endtask

    task automatic pulses(input int n);
        repeat (n)
        begin
            w = 2 + ($unsigned($random(seed)) % 3);
            @(posedge mclk_i);
            event_input_pin_i <= 1'b1;
            repeat (w) @(posedge mclk_i);
            event_input_pin_i <= 1'b0;
            repeat (w) @(posedge mclk_i);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rd(tcm_pkg::TCM_ADDR_CMP_HI, tcm_pkg::TCM_CMP_RESET);
        rd(tcm_pkg::TCM_ADDR_CMP_LO, tcm_pkg::TCM_CMP_RESET);
        rd(tcm_pkg::TCM_ADDR_STATUS, tcm_pkg::TCM_STATUS_RESET);
        rd(tcm_pkg::TCM_ADDR_CONTROL, tcm_pkg::TCM_READ_ZERO);
        wr(tcm_pkg::TCM_ADDR_STATUS, 8'hCC);
        rd(tcm_pkg::TCM_ADDR_STATUS, 8'h00);
        wr(tcm_pkg::TCM_ADDR_CONTROL, 8'h88);
        #1;
        chk1(toggle_pin_high_o, 1'b1);
        chk1(toggle_pin_low_o, 1'b1);
        wr(tcm_pkg::TCM_ADDR_CONTROL, 8'h00);
        #1;
        chk1(toggle_pin_high_o, 1'b0);
        chk1(toggle_pin_low_o, 1'b0);
        $display("test reset and levels done");
        wr(tcm_pkg::TCM_ADDR_CONTROL, 8'h40);
        for (int s = 1; s >= 0; s--)
        begin
            @(posedge mclk_i);
            event_edge_select_i <= s[0];
            repeat (3) @(posedge mclk_i);
            #1;
            tl_cnt = 0;
            pulses(5);
            repeat (4) @(posedge mclk_i);
            #1;
            check(tl_cnt[7:0], 8'h05);
        end
        $display("test event input done");
        wr(tcm_pkg::TCM_ADDR_CONTROL, 8'h47);
        wr(tcm_pkg::TCM_ADDR_CMP_LO, 8'h20);
        rd(tcm_pkg::TCM_ADDR_CMP_LO, 8'h20);
        zero_counters();
        wr(tcm_pkg::TCM_ADDR_STATUS, 8'h01);
        wait_on(0, 200);
        check(counter_low_i, 8'h20);
        chk1(tick_low_o, 1'b1);
        chk1(irq_request_low_o, 1'b1);
        chk1(toggle_pin_low_o, 1'b1);
        chk1(clear_high_o, 1'b0);
        rd(tcm_pkg::TCM_ADDR_STATUS, 8'h05);
        wr(tcm_pkg::TCM_ADDR_STATUS, 8'h01);
        rd(tcm_pkg::TCM_ADDR_STATUS, 8'h01);
        wait_on(0, 200);
        chk1(toggle_pin_low_o, 1'b0);
        wr(tcm_pkg::TCM_ADDR_STATUS, 8'h01);
        rd(tcm_pkg::TCM_ADDR_STATUS, 8'h05);
        wr(tcm_pkg::TCM_ADDR_STATUS, 8'h02);
        wait_on(2, 700);
        chk1(tick_low_o, 1'b1);
        rd(tcm_pkg::TCM_ADDR_STATUS, 8'h0E);
        $display("test eight bit low done");
        for (int k = 0; k < 4; k++)
        begin
            wr(tcm_pkg::TCM_ADDR_CONTROL, {2'b01, k[1:0], 2'b01, k[1:0]});
            repeat (2) @(posedge mclk_i);
            #1;
            th_cnt = 0;
            tl_cnt = 0;
            repeat (64) @(posedge mclk_i);
            #1;
            check(th_cnt[7:0], per64[k]);
            check(tl_cnt[7:0], per64[k]);
        end
        $display("test dividers done");
        wr(tcm_pkg::TCM_ADDR_CONTROL, 8'h07);
        zero_counters();
        wr(tcm_pkg::TCM_ADDR_CMP_HI, 8'h01);
        rd(tcm_pkg::TCM_ADDR_CMP_HI, 8'hFF);
        wr(tcm_pkg::TCM_ADDR_CMP_LO, 8'h10);
        rd(tcm_pkg::TCM_ADDR_CMP_HI, 8'h01);
        rd(tcm_pkg::TCM_ADDR_CMP_LO, 8'h10);
        wr(tcm_pkg::TCM_ADDR_STATUS, 8'h10);
        wait_on(1, 800);
        check(counter_high_i, 8'h01);
        check(counter_low_i, 8'h10);
        chk1(clear_low_o, 1'b1);
        chk1(irq_request_high_o, 1'b1);
        chk1(toggle_pin_high_o, 1'b1);
        rd(tcm_pkg::TCM_ADDR_STATUS, 8'h5C);
        wr(tcm_pkg::TCM_ADDR_STATUS, 8'h20);
        preload <= 16'hFFF0;
        zero_counters();
        wait_on(3, 200);
        chk1(tick_high_o, 1'b1);
        chk1(irq_request_high_o, 1'b1);
        rd(tcm_pkg::TCM_ADDR_STATUS, 8'hA8);
        $display("test sixteen bit done");
        repeat (2) @(posedge mclk_i);
        results();
    end
endmodule // test_timer_compare_control
